// ==== rtl/pmcs_top.sv ====
// pmcs_top: power modes, system clock select, pre-divider and wake control
// assumes AXI4-Lite master on I_CLOCK, slow oscillator and wake lines asynchronous
`timescale 1ns/1ps

// Behaviour
// - stop bit set with sleep clear gates CPU and peripheral clocks, enters stop
// - sleep and stop both set enter sleep, also dropping bandgap and regulator
// - stop ends only on non-clocked wake or reset; stop bit self-clears
// - leaving sleep clears both sleep and stop bits
// - sleep wake waits for regulator settling, extra under 64 fast-osc cycles
// - idle bit stops CPU clock only; external peripherals keep their clocks
// - in idle, external peripheral and pin interrupts wake the CPU
// - idle exits on any wake-line rising edge or I_IDLE_IRQ, unlike stop; idle bit self-clears
// - upper divider bit hardwired zero, always reads zero
// - divide-by-257 mode unreachable; lower bit alone means full speed
// - switch-back bit readable and writable, without functional effect
// - four-bit pre-divider maps codes to 1, even 2..16, 32, 64, 128, 256
// - regulator-ready code picks 8, 16, 64 or 256 slow cycles; longest default
// - source code 0 or 2 fast osc, 1 slow osc, 3 external clock
// - clock select and wake mask writes need open timed window; reads free
// - eight wake mask bits enable internal lines and two pin interrupts
// - enabled wake event restarts fast oscillator and system clock
// - wake detection uses the edge even for level interrupts
// - wake path ignores interrupt enables
// - only pins and non-clocked sources wake from stop or sleep
// - power control bit 7 reserved, no functional effect
// - 0xAA then 0x55 opens a 256-cycle write window
// - stop disables fast oscillator cleanly on its last edge
// - sleep wake re-enables regulator, resumes after regulator-ready delay
module pmcs_top
  import pmcs_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int WAKE_LINES = 8
) (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_SLOW_OSC,
  input wire logic [WAKE_LINES-1:0] I_WAKE_LINES,
  input wire logic I_IDLE_IRQ,
  output pmcs_power_t O_POWER,
  output pmcs_mode_t O_MODE,
  output logic [1:0] O_SYSTEM_CLOCK_SOURCE,
  output logic [8:0] O_PREDIV_FACTOR,
  output logic O_REDUCED_SPEED,
  output logic O_AUTO_RETURN_NORMAL,
  output logic O_WAKE_PULSE,
  output logic O_TA_WINDOW_OPEN
);

  // reset release through two flops
  logic rst_meta_q;
  logic rstn_q;
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rstn_q <= rst_meta_q;
    end
  end

  // three-flop sampling of slow oscillator and wake lines
  localparam int SYNC_W = WAKE_LINES + 1;
  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, stable_q;
  logic [SYNC_W-1:0] stable_d;
  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stable_q <= '0;
    end else begin
      s1_q <= {I_SLOW_OSC, I_WAKE_LINES};
      s2_q <= s1_q;
      s3_q <= s2_q;
      stable_q <= stable_d;
    end
  end
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
    end
  end
  logic [SYNC_W-1:0] rise;
  assign rise = stable_d & ~stable_q;
  logic slow_tick;
  assign slow_tick = rise[SYNC_W-1];

  // register state
  logic baud_double_reserved_q;
  logic sleep_q, stop_q, idle_q;
  logic divider_ctl_low_q, auto_return_normal_q;
  logic [7:0] clock_source_select_q;
  logic [7:0] wake_source_mask_q;
  pmcs_mode_t mode_q, mode_d;

  // AXI write channel capture
  logic aw_have_q, w_have_q, bvalid_q;
  logic [7:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  assign O_AWREADY = !aw_have_q && !bvalid_q;
  assign O_WREADY = !w_have_q && !bvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= '0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= I_AWADDR[9:2];
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_have_q <= 1'b1;
        wbyte_q <= I_WDATA[7:0];
        wlane_q <= I_WSTRB[0];
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx == IDX_POWER_CONTROL) || (idx == IDX_CLOCK_SOURCE_SELECT) ||
      (idx == IDX_WAKE_SOURCE_MASK) || (idx == IDX_SPEED_MODE_CONTROL) ||
      (idx == IDX_TIMED_ACCESS);
  endfunction

  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= idx_mapped(aw_idx_q) ? AXI_OKAY : AXI_SLVERR;
    end else if (I_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;

  logic wr_en;
  assign wr_en = wr_fire && wlane_q;
  function automatic logic wr_to(input logic [7:0] idx, input logic [7:0] tgt);
    wr_to = idx == tgt;
  endfunction

  localparam int TA_CNT_W = $clog2(TA_WINDOW_CYCLES + 1);
  localparam logic [TA_CNT_W-1:0] TA_LOAD = TA_CNT_W'(TA_WINDOW_CYCLES);
  logic ta_armed_q;
  logic [TA_CNT_W-1:0] ta_cnt_q;
  logic ta_open;
  assign ta_open = ta_cnt_q != '0;
  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      ta_armed_q <= 1'b0;
      ta_cnt_q <= '0;
    end else if (wr_en && wr_to(aw_idx_q, IDX_TIMED_ACCESS)) begin
      ta_armed_q <= wbyte_q == TA_KEY_FIRST;
      if (ta_armed_q && wbyte_q == TA_KEY_SECOND) begin
        ta_cnt_q <= TA_LOAD;
      end else if (wbyte_q == TA_KEY_CLOSE) begin
        ta_cnt_q <= '0;
      end else if (ta_open) begin
        ta_cnt_q <= ta_cnt_q - 1'b1;
      end
    end else if (ta_open) begin
      ta_cnt_q <= ta_cnt_q - 1'b1;
    end
  end

  logic wr_clock_source_select, wr_mask, wr_power_control, wr_pmr;
  assign wr_clock_source_select = wr_en && wr_to(aw_idx_q, IDX_CLOCK_SOURCE_SELECT) && ta_open;
  assign wr_mask = wr_en && wr_to(aw_idx_q, IDX_WAKE_SOURCE_MASK) && ta_open;
  assign wr_power_control = wr_en && wr_to(aw_idx_q, IDX_POWER_CONTROL);
  assign wr_pmr = wr_en && wr_to(aw_idx_q, IDX_SPEED_MODE_CONTROL);

  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      clock_source_select_q <= RST_CLOCK_SOURCE_SELECT;
      wake_source_mask_q <= RST_WAKE_SOURCE_MASK;
    end else begin
      if (wr_clock_source_select) begin
        clock_source_select_q <= wbyte_q;
      end
      if (wr_mask) begin
        wake_source_mask_q <= wbyte_q;
      end
    end
  end

  // switch-back stored only; upper bit never stored
  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      divider_ctl_low_q <= RST_DIVIDER_CTL_LOW;
      auto_return_normal_q <= RST_AUTO_RETURN_NORMAL;
    end else if (wr_pmr) begin
      divider_ctl_low_q <= wbyte_q[POS_DIV_LOW];
      auto_return_normal_q <= wbyte_q[POS_AUTO_RET];
    end
  end

  // wake sources
  logic mask_wake, idle_wake;
  // independent of interrupt enables; only masked async lines
  assign mask_wake = |(rise[WAKE_LINES-1:0] & wake_source_mask_q);
  // idle also woken by clocked peripheral interrupts
  assign idle_wake = I_IDLE_IRQ || (|rise[WAKE_LINES-1:0]);

  // regulator-ready delay counter on slow-oscillator edges
  logic [8:0] rdy_cnt_q;
  logic [8:0] rdy_load;
  always_comb begin
    case (clock_source_select_q[POS_REGRDY_LSB +: 2])
      2'h0: rdy_load = REGRDY_CODE0;
      2'h1: rdy_load = REGRDY_CODE1;
      2'h2: rdy_load = REGRDY_CODE2;
      default: rdy_load = REGRDY_CODE3;
    endcase
  end

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_WAKE_DELAY: begin
        if (rdy_cnt_q == '0) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_RUN: begin
        if (sleep_q && stop_q) begin
          mode_d = MODE_SLEEP;
        end else if (stop_q) begin
          mode_d = MODE_STOP;
        end else if (idle_q) begin
          mode_d = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (idle_wake) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_STOP: begin
        // only a masked async wake leaves stop
        if (mask_wake) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_SLEEP: begin
        if (mask_wake) begin
          mode_d = MODE_WAKE_DELAY;
        end
      end
      default: mode_d = MODE_RUN;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      mode_q <= MODE_WAKE_DELAY;
    end else begin
      mode_q <= mode_d;
    end
  end

  // delay also applies after reset, default code is longest
  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      rdy_cnt_q <= REGRDY_CODE3;
    end else if (mode_q == MODE_SLEEP && mode_d == MODE_WAKE_DELAY) begin
      rdy_cnt_q <= rdy_load;
    end else if (mode_q == MODE_WAKE_DELAY && slow_tick && rdy_cnt_q != '0) begin
      rdy_cnt_q <= rdy_cnt_q - 1'b1;
    end
  end

  // power control bits, hardware clear on mode exit
  logic leave_stop, leave_sleep, leave_idle;
  assign leave_stop = mode_q == MODE_STOP && mode_d == MODE_RUN;
  assign leave_sleep = mode_q == MODE_WAKE_DELAY && mode_d == MODE_RUN;
  assign leave_idle = mode_q == MODE_IDLE && mode_d == MODE_RUN;
  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      baud_double_reserved_q <= RST_POWER_CONTROL[POS_BAUD_DOUBLE];
      sleep_q <= RST_POWER_CONTROL[POS_SLEEP];
      stop_q <= RST_POWER_CONTROL[POS_STOP];
      idle_q <= RST_POWER_CONTROL[POS_IDLE];
    end else if (wr_power_control) begin
      baud_double_reserved_q <= wbyte_q[POS_BAUD_DOUBLE];
      sleep_q <= wbyte_q[POS_SLEEP];
      stop_q <= wbyte_q[POS_STOP];
      idle_q <= wbyte_q[POS_IDLE];
    end else begin
      if (leave_sleep) begin
        sleep_q <= 1'b0;
        stop_q <= 1'b0;
      end
      if (leave_stop) begin
        stop_q <= 1'b0;
      end
      if (leave_idle || leave_stop || leave_sleep) begin
        idle_q <= 1'b0;
      end
    end
  end

  // power gating, registered from next mode
  function automatic pmcs_power_t power_of(input pmcs_mode_t m);
    pmcs_power_t p;
    p = '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, fast_osc_en: 1'b1,
      regulator_en: 1'b1, bandgap_en: 1'b1};
    case (m)
      MODE_IDLE: p.cpu_clk_en = 1'b0;
      // stop gates all clocks; oscillator off
      MODE_STOP: begin
        p.cpu_clk_en = 1'b0;
        p.periph_clk_en = 1'b0;
        p.fast_osc_en = 1'b0;
      end
      // sleep also drops bandgap and regulator
      MODE_SLEEP: p = '0;
      // regulator on, clocks held during settling
      MODE_WAKE_DELAY: begin
        p.cpu_clk_en = 1'b0;
        p.periph_clk_en = 1'b0;
        p.fast_osc_en = 1'b0;
      end
      default: p = p;
    endcase
    power_of = p;
  endfunction

  // idle keeps peripheral clocks; wake restores oscillator and clock
  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      O_POWER <= '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0, fast_osc_en: 1'b0,
        regulator_en: 1'b1, bandgap_en: 1'b1};
      O_WAKE_PULSE <= 1'b0;
    end else begin
      O_POWER <= power_of(mode_d);
      O_WAKE_PULSE <= leave_stop || leave_sleep || leave_idle;
    end
  end
  assign O_MODE = mode_q;

  function automatic logic [8:0] prediv(input logic [3:0] code);
    case (code)
      4'h0: prediv = 9'h001;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: prediv = {4'h0, code, 1'b0};
      4'h9: prediv = 9'h020;
      4'hA: prediv = 9'h040;
      4'hB: prediv = 9'h080;
      default: prediv = 9'h100;
    endcase
  endfunction

  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      O_PREDIV_FACTOR <= 9'h001;
      O_SYSTEM_CLOCK_SOURCE <= SRC_FAST_OSC;
      O_AUTO_RETURN_NORMAL <= RST_AUTO_RETURN_NORMAL;
      O_TA_WINDOW_OPEN <= 1'b0;
    end else begin
      O_PREDIV_FACTOR <= prediv(clock_source_select_q[POS_PREDIV_LSB +: 4]);
      // codes 0 and 2 both mean fast oscillator
      O_SYSTEM_CLOCK_SOURCE <= (clock_source_select_q[1:0] == SRC_FAST_OSC_ALT) ? SRC_FAST_OSC :
        clock_source_select_q[1:0];
      O_AUTO_RETURN_NORMAL <= auto_return_normal_q;
      O_TA_WINDOW_OPEN <= ta_open;
    end
  end
  // needs both divider bits, upper one is fixed zero
  assign O_REDUCED_SPEED = 1'b0;

  // read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_byte;
  logic [7:0] ar_idx;
  assign ar_idx = I_ARADDR[9:2];
  always_comb begin
    rd_byte = 8'h00;
    case (ar_idx)
      IDX_POWER_CONTROL: rd_byte[POS_BAUD_DOUBLE] = baud_double_reserved_q;
      IDX_CLOCK_SOURCE_SELECT: begin
        rd_byte[POS_PREDIV_LSB +: 4] = clock_source_select_q[POS_PREDIV_LSB +: 4];
        rd_byte[POS_SRC_LSB +: 2] = clock_source_select_q[POS_SRC_LSB +: 2];
      end
      IDX_WAKE_SOURCE_MASK: rd_byte = wake_source_mask_q;
      IDX_SPEED_MODE_CONTROL: begin
        rd_byte[POS_DIV_HIGH] = 1'b0;
        rd_byte[POS_DIV_LOW] = divider_ctl_low_q;
        rd_byte[POS_AUTO_RET] = auto_return_normal_q;
      end
      IDX_TIMED_ACCESS: rd_byte[0] = ta_open;
      default: rd_byte = 8'h00;
    endcase
  end
  assign O_ARREADY = !rvalid_q;
  always_ff @(posedge I_CLOCK or negedge rstn_q) begin
    if (!rstn_q) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= AXI_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= idx_mapped(ar_idx) ? AXI_OKAY : AXI_SLVERR;
    end else if (I_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;

endmodule

// ==== rtl/pmcs_pkg.sv ====
// pmcs_pkg: shared constants and types of the power-mode and clock-select block
// assumes a 32-bit AXI4-Lite register bus, register byte address = 4 * index
package pmcs_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_CLOCK_SOURCE_SELECT = 8'h8F;
  localparam logic [7:0] IDX_WAKE_SOURCE_MASK = 8'h9F;
  localparam logic [7:0] IDX_SPEED_MODE_CONTROL = 8'hC4;
  localparam logic [7:0] IDX_TIMED_ACCESS = 8'hC9;

  // reset values
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_SOURCE_SELECT = 8'h0C;
  localparam logic [7:0] RST_WAKE_SOURCE_MASK = 8'hFF;
  localparam logic RST_DIVIDER_CTL_LOW = 1'b1;
  localparam logic RST_AUTO_RETURN_NORMAL = 1'b0;

  // field positions
  localparam int POS_BAUD_DOUBLE = 7;
  localparam int POS_SLEEP = 2;
  localparam int POS_STOP = 1;
  localparam int POS_IDLE = 0;
  localparam int POS_DIV_HIGH = 7;
  localparam int POS_DIV_LOW = 6;
  localparam int POS_AUTO_RET = 5;
  localparam int POS_PREDIV_LSB = 4;
  localparam int POS_REGRDY_LSB = 2;
  localparam int POS_SRC_LSB = 0;

  // timed-access unlock sequence and window
  localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [7:0] TA_KEY_CLOSE = 8'h00;
  localparam int TA_WINDOW_CYCLES = 256;

  // regulator-ready delays in slow-oscillator cycles
  localparam logic [8:0] REGRDY_CODE0 = 9'h008;
  localparam logic [8:0] REGRDY_CODE1 = 9'h010;
  localparam logic [8:0] REGRDY_CODE2 = 9'h040;
  localparam logic [8:0] REGRDY_CODE3 = 9'h100;

  // system clock source codes
  localparam logic [1:0] SRC_FAST_OSC = 2'h0;
  localparam logic [1:0] SRC_SLOW_OSC = 2'h1;
  localparam logic [1:0] SRC_FAST_OSC_ALT = 2'h2;
  localparam logic [1:0] SRC_EXT_CLOCK_IN = 2'h3;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_WAKE_DELAY, MODE_RUN, MODE_IDLE, MODE_STOP, MODE_SLEEP
  } pmcs_mode_t;

  // gates and supplies steered by the power mode
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic fast_osc_en;
    logic regulator_en;
    logic bandgap_en;
  } pmcs_power_t;

endpackage

// ==== sim/pmcs_top_monitor.sv ====
// pmcs_top_monitor: concurrent checks on the power-mode block ports
// assumes binding into pmcs_top, single I_CLOCK domain
`timescale 1ns/1ps
module pmcs_top_monitor
  import pmcs_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic I_BREADY,
  input wire logic O_BVALID,
  input wire pmcs_power_t O_POWER,
  input wire pmcs_mode_t O_MODE,
  input wire logic [1:0] O_SYSTEM_CLOCK_SOURCE,
  input wire logic [8:0] O_PREDIV_FACTOR,
  input wire logic O_REDUCED_SPEED,
  input wire logic O_WAKE_PULSE,
  input wire logic O_TA_WINDOW_OPEN
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  logic [9:0] open_cnt_q;

  // length of the current open window
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      open_cnt_q <= 10'h000;
    end else if (O_TA_WINDOW_OPEN) begin
      open_cnt_q <= open_cnt_q + 10'h001;
    end else begin
      open_cnt_q <= 10'h000;
    end
  end

  AST_RUN_POWER: assert property ((O_MODE == MODE_RUN)[*3] |->
    $past(O_POWER) == 5'h1F) else $error("clock or supply off in run");
  AST_STOP_POWER: assert property ((O_MODE == MODE_STOP)[*3] |->
    $past(O_POWER) == 5'h03) else $error("gating wrong in stop");
  AST_SLEEP_POWER: assert property ((O_MODE == MODE_SLEEP)[*3] |->
    $past(O_POWER) == 5'h00) else $error("gating wrong in sleep");
  AST_IDLE_POWER: assert property ((O_MODE == MODE_IDLE)[*3] |->
    $past(O_POWER) == 5'h0F) else $error("gating wrong in idle");
  AST_WAKE_PULSE: assert property ((O_MODE == MODE_RUN &&
    ($past(O_MODE) == MODE_IDLE || $past(O_MODE) == MODE_STOP)) |-> ##[0:1] O_WAKE_PULSE)
    else $error("no wake pulse on return to run");
  AST_PULSE_ONE: assert property (O_WAKE_PULSE |=> !O_WAKE_PULSE)
    else $error("wake pulse longer than one cycle");
  AST_NO_PMM: assert property (!O_REDUCED_SPEED)
    else $error("reduced speed reached");
  AST_SRC_CODE: assert property (O_SYSTEM_CLOCK_SOURCE != 2'h2)
    else $error("source code 2 not folded to fast osc");
  AST_PREDIV_SET: assert property (O_PREDIV_FACTOR inside {9'h001, 9'h002, 9'h004,
    9'h006, 9'h008, 9'h00A, 9'h00C, 9'h00E, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100})
    else $error("illegal divide ratio");
  AST_TA_LIMIT: assert property (open_cnt_q <= 10'h101)
    else $error("write window open too long");
  AST_B_DROP: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response not released");

  cover property ((O_MODE == MODE_STOP)[*3]);
  cover property ((O_MODE == MODE_SLEEP)[*3]);
  cover property ((O_MODE == MODE_IDLE)[*3]);
  cover property (O_WAKE_PULSE);
endmodule

bind pmcs_top pmcs_top_monitor i_mon (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN),
  .I_BREADY(I_BREADY), .O_BVALID(O_BVALID), .O_POWER(O_POWER), .O_MODE(O_MODE),
  .O_SYSTEM_CLOCK_SOURCE(O_SYSTEM_CLOCK_SOURCE), .O_PREDIV_FACTOR(O_PREDIV_FACTOR),
  .O_REDUCED_SPEED(O_REDUCED_SPEED), .O_WAKE_PULSE(O_WAKE_PULSE),
  .O_TA_WINDOW_OPEN(O_TA_WINDOW_OPEN));

// ==== sim/pmcs_wake_src.sv ====
// pmcs_wake_src: slow oscillator and wake sources around the block
// assumes calls made just after a rising edge of i_clk
`timescale 1ns/1ps
module pmcs_wake_src (
  input wire logic i_clk,
  output logic o_slow_osc,
  output logic [7:0] o_wake_lines,
  output logic o_idle_irq
);
  initial begin
    o_slow_osc = 1'b0;
    o_wake_lines = 8'h00;
    o_idle_irq = 1'b0;
  end

  // non-stop oscillator, phase unrelated to i_clk
  always #203 o_slow_osc = ~o_slow_osc;

  task automatic pulse_line(input int b);
    o_wake_lines[b] <= 1'b1;
    repeat (6) @(posedge i_clk);
    o_wake_lines[b] <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  task automatic raise_irq();
    o_idle_irq <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_idle_irq <= 1'b0;
    @(posedge i_clk);
  endtask
endmodule

// ==== sim/pmcs_top_tb_top.sv ====
// pmcs_top_tb_top: directed scenarios for the power-mode block
// assumes pmcs_wake_src as far side, checker bound to pmcs_top
`timescale 1ns/1ps
module pmcs_top_tb_top import pmcs_pkg::*; ;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, bvalid, arready, rvalid;
  logic awready, wready, slow_osc, idle_irq, red, auto_ret, wpulse, ta_open;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, last_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, src, last_resp;
  logic [7:0] wake;
  logic [8:0] prediv;
  pmcs_power_t pwr;
  pmcs_mode_t mode;
  int num_errors, total_checks, waited;
  logic [8:0] pd_tab [16] = '{9'h001, 9'h002, 9'h004, 9'h006, 9'h008, 9'h00A, 9'h00C,
    9'h00E, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100, 9'h100, 9'h100, 9'h100};

  pmcs_top i_dut (.I_CLOCK(clk), .I_RSTN(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_SLOW_OSC(slow_osc),
    .I_WAKE_LINES(wake), .I_IDLE_IRQ(idle_irq), .O_POWER(pwr), .O_MODE(mode),
    .O_SYSTEM_CLOCK_SOURCE(src), .O_PREDIV_FACTOR(prediv), .O_REDUCED_SPEED(red),
    .O_AUTO_RETURN_NORMAL(auto_ret), .O_WAKE_PULSE(wpulse), .O_TA_WINDOW_OPEN(ta_open));
  pmcs_wake_src i_src (.i_clk(clk), .o_slow_osc(slow_osc), .o_wake_lines(wake),
    .o_idle_irq(idle_irq));

  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a, w, done;
    a = 1'b1;
    w = 1'b1;
    done = 1'b0;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        last_resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] idx);
    logic a, done;
    a = 1'b1;
    done = 1'b0;
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (a && arready) begin
        a = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        last_data = rdata;
        last_resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(last_data, {24'h000000, exp});
  endtask

  task automatic wait_mode(input pmcs_mode_t m, input int lim);
    waited = 0;
    while (mode !== m && waited < lim) begin
      @(posedge clk);
      waited++;
    end
    chk({29'h0, mode}, {29'h0, m});
  endtask

  task automatic t_regs();
    rd_chk(IDX_POWER_CONTROL, 8'h00);
    rd_chk(IDX_CLOCK_SOURCE_SELECT, 8'h00);
    rd_chk(IDX_WAKE_SOURCE_MASK, 8'hFF);
    rd_chk(IDX_SPEED_MODE_CONTROL, 8'h40);
    wr(IDX_SPEED_MODE_CONTROL, 8'hFF);
    rd_chk(IDX_SPEED_MODE_CONTROL, 8'h60);
    chk({30'h0, red, auto_ret}, 32'h1);
    wr(IDX_POWER_CONTROL, 8'h80);
    rd_chk(IDX_POWER_CONTROL, 8'h80);
    chk({29'h0, mode}, {29'h0, MODE_RUN});
    rd(8'h10);
    chk({30'h0, last_resp}, {30'h0, AXI_SLVERR});
    wr(8'h10, 8'hFF);
    chk({30'h0, last_resp}, {30'h0, AXI_SLVERR});
  endtask

  task automatic t_protect();
    wr(IDX_CLOCK_SOURCE_SELECT, 8'h31);
    rd_chk(IDX_CLOCK_SOURCE_SELECT, 8'h00);
    wr(IDX_TIMED_ACCESS, TA_KEY_FIRST);
    wr(IDX_TIMED_ACCESS, TA_KEY_SECOND);
    rd_chk(IDX_TIMED_ACCESS, 8'h01);
    for (int i = 0; i < 16; i++) begin
      wr(IDX_CLOCK_SOURCE_SELECT, {i[3:0], 2'b00, i[1:0]});
      chk({23'h0, prediv}, {23'h0, pd_tab[i]});
      chk({30'h0, src}, {30'h0, (i[1:0] == 2'h2) ? 2'h0 : i[1:0]});
    end
    rd_chk(IDX_CLOCK_SOURCE_SELECT, 8'hF3);
    wr(IDX_CLOCK_SOURCE_SELECT, 8'h00);
    wr(IDX_WAKE_SOURCE_MASK, 8'h04);
    wr(IDX_TIMED_ACCESS, TA_KEY_CLOSE);
    chk({31'h0, ta_open}, 32'h0);
    wr(IDX_WAKE_SOURCE_MASK, 8'hFF);
    rd_chk(IDX_WAKE_SOURCE_MASK, 8'h04);
  endtask

  task automatic t_stop();
    wr(IDX_POWER_CONTROL, 8'h02);
    wait_mode(MODE_STOP, 10);
    chk({27'h0, pwr}, 32'h03);
    i_src.pulse_line(0);
    chk({29'h0, mode}, {29'h0, MODE_STOP});
    i_src.pulse_line(2);
    wait_mode(MODE_RUN, 20);
    repeat (4) @(posedge clk);
    chk({29'h0, mode}, {29'h0, MODE_RUN});
  endtask

  task automatic t_sleep();
    wr(IDX_POWER_CONTROL, 8'h06);
    wait_mode(MODE_SLEEP, 10);
    chk({27'h0, pwr}, 32'h00);
    i_src.pulse_line(2);
    chk({29'h0, mode}, {29'h0, MODE_WAKE_DELAY});
    wait_mode(MODE_RUN, 200);
    chk({31'h0, waited >= 60 && waited <= 100}, 32'h1);
    repeat (4) @(posedge clk);
    chk({29'h0, mode}, {29'h0, MODE_RUN});
  endtask

  task automatic t_idle();
    wr(IDX_POWER_CONTROL, 8'h01);
    wait_mode(MODE_IDLE, 10);
    chk({27'h0, pwr}, 32'h0F);
    i_src.raise_irq();
    wait_mode(MODE_RUN, 10);
    repeat (4) @(posedge clk);
    chk({29'h0, mode}, {29'h0, MODE_RUN});
    wr(IDX_POWER_CONTROL, 8'h03);
    wait_mode(MODE_STOP, 10);
    i_src.pulse_line(2);
    wait_mode(MODE_RUN, 20);
    repeat (4) @(posedge clk);
    chk({29'h0, mode}, {29'h0, MODE_RUN});
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    num_errors = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_mode(MODE_RUN, 3000);
    chk({31'h0, waited >= 2550 && waited <= 2700}, 32'h1);
    t_regs();
    t_protect();
    t_stop();
    t_sleep();
    t_idle();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule
